// ### src/hsc_pkg.sv
// Shared constants, register map and carrier types of the HALT standby controller.
package hsc_pkg;

  // Interrupt sources watched while halted.
  localparam int IRQ_COUNT = 8;

  // APB register map, byte addresses.
  localparam int APB_ADDR_WIDTH = 8;
  localparam logic [APB_ADDR_WIDTH-1:0] CTRL_ADDR          = 8'h00;
  localparam logic [APB_ADDR_WIDTH-1:0] STATUS_ADDR        = 8'h04;
  localparam logic [APB_ADDR_WIDTH-1:0] RELEASE_COUNT_ADDR = 8'h08;

  // Release wait lengths in CPU clocks; an odd phase adds one clock.
  localparam int WAIT_WIDTH = 5;
  localparam logic [WAIT_WIDTH-1:0] VECTOR_WAIT_CYCLES = 5'h0b;
  localparam logic [WAIT_WIDTH-1:0] NEXT_WAIT_CYCLES   = 5'h04;
  localparam logic [WAIT_WIDTH-1:0] WAIT_ONE           = 5'h01;

  // Width of the HALT release counter.
  localparam int RELEASE_COUNT_WIDTH = 16;
  localparam logic [RELEASE_COUNT_WIDTH-1:0] RELEASE_COUNT_STEP = 16'h0001;

  // Controller states, one-hot.
  typedef enum logic [3:0] {
    ST_RUN       = 4'h1,
    ST_HALT      = 4'h2,
    ST_WAIT_VEC  = 4'h4,
    ST_WAIT_NEXT = 4'h8
  } hsc_state_type;

  // Software clock and peripheral controls, low bits of the control word.
  typedef struct packed {
    logic subOsc;
    logic periphClockStop;
    logic timer16Run;
    logic lowOscStop;
    logic crystalOsc;
    logic fastOsc;
  } hsc_ctrl_type;

  localparam int CTRL_WIDTH = $bits(hsc_ctrl_type);
  localparam hsc_ctrl_type CTRL_RESET = '{subOsc: 1'b1, periphClockStop: 1'b0, timer16Run: 1'b0,
                                         lowOscStop: 1'b0, crystalOsc: 1'b0, fastOsc: 1'b1};

  // Status word, low bits.
  typedef struct packed {
    logic          lowOscStoppable;
    logic          haltFromSub;
    logic          lastResume;
    logic          lastService;
    hsc_state_type state;
  } hsc_status_type;

  localparam int STATUS_WIDTH = $bits(hsc_status_type);

  // Flags presented by the interrupt controller, one bit per source.
  typedef struct packed {
    logic [IRQ_COUNT-1:0] request;
    logic [IRQ_COUNT-1:0] mask;
    logic [IRQ_COUNT-1:0] lowPriority;
  } hsc_irq_flags_type;

endpackage : hsc_pkg

// ### src/hsc_irq_release.sv
// Per-source HALT release and service decision from the interrupt controller flags.
`timescale 1ns/1ps
module hsc_irq_release (
  // Interrupt controller flags
  input  hsc_pkg::hsc_irq_flags_type irqFlags,
  input  wire logic                  globalIrqEnable,
  input  wire logic                  inServicePriorityFlag,
  // Decision
  output logic                       releaseAny,
  output logic                       serviceAny
);

  logic [hsc_pkg::IRQ_COUNT-1:0] unmasked;
  logic [hsc_pkg::IRQ_COUNT-1:0] serviced;

  // Each source releases when requested and unmasked, and is serviced by priority.
  for (genvar i = 0; i < hsc_pkg::IRQ_COUNT; i++) begin : g_source
    assign unmasked[i] = irqFlags.request[i] & ~irqFlags.mask[i];                        // [R10]
    assign serviced[i] = unmasked[i] & globalIrqEnable
                         & (~irqFlags.lowPriority[i] | inServicePriorityFlag);          // [R11]
  end

  // Any unmasked source ends HALT; vectoring needs at least one serviceable one.
  assign releaseAny = |unmasked;                                                        // [R7]
  assign serviceAny = |serviced;                                                        // [R11]

endmodule : hsc_irq_release

// ### src/hsc_wait_counter.sv
// Down counter that times the wait between HALT release and execution.
`timescale 1ns/1ps
module hsc_wait_counter (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            reset_n,
  // Control
  input  wire logic                            load,
  input  wire logic [hsc_pkg::WAIT_WIDTH-1:0]  loadValue,
  // Result
  output logic                                 done
);

  logic [hsc_pkg::WAIT_WIDTH-1:0] count;
  logic [hsc_pkg::WAIT_WIDTH-1:0] next_count;
  logic                           next_done;

  // Load takes priority; the last count step raises a one-cycle done.
  assign next_count = load ? loadValue : ((count != '0) ? count - hsc_pkg::WAIT_ONE : count);
  assign next_done  = !load && (count == hsc_pkg::WAIT_ONE);

  // Counter and done flag.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule : hsc_wait_counter

// ### src/hsc_halt_control.sv
// HALT standby controller: clock gating, hold, release decision and wait timing.
//
// Operation
// [R1] Sub-clock HALT: gate CPU clock, keep sub oscillator
// [R2] Other oscillators keep their pre-HALT state
// [R3] HALT stops execution, freezes held state
// [R4] 16-bit timer runs unless peripheral clock stopped
// [R5] Watchdog clock cut only when option allows
// [R6] Software avoids external-clock peripherals on sub-clock
// [R7] Unmasked request ends HALT, vector or resume
// [R8] Wait 11/12 clocks vectoring, 4/5 resuming
// [R9] Reset ends HALT, branch to reset vector
// [R10] Masked request keeps the device halted
// [R11] Enable and priority flags choose service or resume
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module hsc_halt_control (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 reset_n,
  // CPU core
  input  wire logic                                 haltEntry,
  input  wire logic                                 cpuOnSubClock,
  // Option strap, caught after reset release
  input  wire logic                                 optionLowOscStoppable,
  // Interrupt controller flags
  input  hsc_pkg::hsc_irq_flags_type                irqFlags,
  input  wire logic                                 globalIrqEnable,
  input  wire logic                                 inServicePriorityFlag,
  // APB slave
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [hsc_pkg::APB_ADDR_WIDTH-1:0]   paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // Clock and execution controls
  output logic                                      cpuClockEnable,
  output logic                                      executionHold,
  output logic                                      subOscEnable,
  output logic                                      fastOscEnable,
  output logic                                      crystalOscEnable,
  output logic                                      lowSpeedOscEnable,
  output logic                                      watchdogClockEnable,
  output logic                                      timer16Enable,
  // Restart pulses to the CPU
  output logic                                      vectorStart,
  output logic                                      resumeStart,
  output logic                                      resetVectorStart
);

  // State and control storage.
  hsc_pkg::hsc_state_type                          state;
  hsc_pkg::hsc_state_type                          next_state;
  hsc_pkg::hsc_ctrl_type                           ctrl;
  hsc_pkg::hsc_ctrl_type                           next_ctrl;
  logic                                            haltFromSub;
  logic                                            next_haltFromSub;
  logic                                            lastService;
  logic                                            lastResume;
  logic                                            optionCaptured;
  logic                                            lowOscStoppable;
  logic                                            waitPhase;
  logic                                            resetBranchDone;
  logic [hsc_pkg::RELEASE_COUNT_WIDTH-1:0]         releaseCount;

  // Decision and timing wires.
  logic                                            releaseAny;
  logic                                            serviceAny;
  logic                                            releaseNow;
  logic                                            loadWait;
  logic [hsc_pkg::WAIT_WIDTH-1:0]                  baseWait;
  logic [hsc_pkg::WAIT_WIDTH-1:0]                  waitValue;
  logic                                            waitDone;
  logic                                            inHalt;
  logic                                            nextInHalt;
  logic                                            nextRunning;

  // APB wires.
  logic                                            setupPhase;
  logic                                            accessDone;
  logic                                            hitCtrl;
  logic                                            hitStatus;
  logic                                            hitCount;
  logic                                            hitAny;
  logic                                            ctrlWriteRefused;
  logic                                            ctrlWrite;
  hsc_pkg::hsc_status_type                         statusWord;
  logic [31:0]                                     readWord;
  logic [31:0]                                     next_prdata;
  logic                                            next_pslverr;

  // Release decision over all interrupt sources.
  hsc_irq_release u_irq_release (
    .irqFlags              (irqFlags),
    .globalIrqEnable       (globalIrqEnable),
    .inServicePriorityFlag (inServicePriorityFlag),
    .releaseAny            (releaseAny),
    .serviceAny            (serviceAny)
  );

  // Release wait timer.
  hsc_wait_counter u_wait_counter (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .load      (loadWait),
    .loadValue (waitValue),
    .done      (waitDone)
  );

  // State decode.
  assign inHalt = (state == hsc_pkg::ST_HALT);

  // A masked request leaves releaseAny low, so HALT simply holds.
  assign releaseNow = inHalt && releaseAny;                                             // [R10]
  assign loadWait   = releaseNow;                                                       // [R7]

  // Wait length by release kind; the odd phase adds the extra clock.
  assign baseWait  = serviceAny ? hsc_pkg::VECTOR_WAIT_CYCLES : hsc_pkg::NEXT_WAIT_CYCLES; // [R8]
  assign waitValue = waitPhase ? baseWait + hsc_pkg::WAIT_ONE : baseWait;               // [R8]

  // Next state of the standby sequence.
  always_comb begin
    next_state = state;
    case (state)
      hsc_pkg::ST_RUN: begin
        if (haltEntry) begin
          next_state = hsc_pkg::ST_HALT;
        end
      end
      hsc_pkg::ST_HALT: begin
        if (releaseAny) begin
          next_state = serviceAny ? hsc_pkg::ST_WAIT_VEC : hsc_pkg::ST_WAIT_NEXT;       // [R11]
        end
      end
      hsc_pkg::ST_WAIT_VEC: begin
        if (waitDone) begin
          next_state = hsc_pkg::ST_RUN;
        end
      end
      hsc_pkg::ST_WAIT_NEXT: begin
        if (waitDone) begin
          next_state = hsc_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = hsc_pkg::ST_RUN;
      end
    endcase
  end

  // Clock source at HALT entry is latched for the whole standby period.
  assign next_haltFromSub = (state == hsc_pkg::ST_RUN && haltEntry) ? cpuOnSubClock : haltFromSub;
  assign nextInHalt       = (next_state == hsc_pkg::ST_HALT);
  assign nextRunning      = (next_state == hsc_pkg::ST_RUN);

  // Reset returns to RUN from any state, halted ones included.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state       <= hsc_pkg::ST_RUN;                                                   // [R9]
      haltFromSub <= 1'b0;
    end else begin
      state       <= next_state;
      haltFromSub <= next_haltFromSub;
    end
  end

  // Free-running phase that decides the extra wait clock.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      waitPhase <= 1'b0;
    end else begin
      waitPhase <= ~waitPhase;
    end
  end

  // Option strap is sampled once, on the first clock after reset release.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      optionCaptured  <= 1'b0;
      lowOscStoppable <= 1'b0;
    end else if (!optionCaptured) begin
      optionCaptured  <= 1'b1;
      lowOscStoppable <= optionLowOscStoppable;
    end
  end

  // Record of the most recent release and a count of releases.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lastService  <= 1'b0;
      lastResume   <= 1'b0;
      releaseCount <= '0;
    end else if (releaseNow) begin
      lastService  <= serviceAny;
      lastResume   <= ~serviceAny;
      releaseCount <= releaseCount + hsc_pkg::RELEASE_COUNT_STEP;
    end
  end

  // Restart pulses; the reset-vector branch fires once after reset release.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      vectorStart      <= 1'b0;
      resumeStart      <= 1'b0;
      resetVectorStart <= 1'b0;
      resetBranchDone  <= 1'b0;
    end else begin
      vectorStart      <= waitDone && (state == hsc_pkg::ST_WAIT_VEC);                  // [R8]
      resumeStart      <= waitDone && (state == hsc_pkg::ST_WAIT_NEXT);                 // [R8]
      resetVectorStart <= ~resetBranchDone;                                             // [R9]
      resetBranchDone  <= 1'b1;
    end
  end

  // Clock and hold outputs follow the next state so they line up with it.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cpuClockEnable <= 1'b1;
      executionHold  <= 1'b0;
      subOscEnable   <= hsc_pkg::CTRL_RESET.subOsc;
    end else begin
      cpuClockEnable <= ~nextInHalt;                                                    // [R1]
      executionHold  <= ~nextRunning;                                                   // [R3]
      subOscEnable   <= next_ctrl.subOsc | (nextInHalt & next_haltFromSub);             // [R1]
    end
  end

  // Main and low-speed oscillators, watchdog and timer gating.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fastOscEnable       <= hsc_pkg::CTRL_RESET.fastOsc;
      crystalOscEnable    <= hsc_pkg::CTRL_RESET.crystalOsc;
      lowSpeedOscEnable   <= 1'b1;
      watchdogClockEnable <= 1'b1;
      timer16Enable       <= 1'b0;
    end else begin
      fastOscEnable       <= next_ctrl.fastOsc;                                         // [R2]
      crystalOscEnable    <= next_ctrl.crystalOsc;                                      // [R2]
      lowSpeedOscEnable   <= ~(next_ctrl.lowOscStop & lowOscStoppable);                 // [R2]
      watchdogClockEnable <= ~(next_ctrl.lowOscStop & lowOscStoppable);                 // [R5]
      timer16Enable       <= next_ctrl.timer16Run & ~next_ctrl.periphClockStop;         // [R4]
    end
  end

  // APB phase and address decode.
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign hitCtrl    = (paddr == hsc_pkg::CTRL_ADDR);
  assign hitStatus  = (paddr == hsc_pkg::STATUS_ADDR);
  assign hitCount   = (paddr == hsc_pkg::RELEASE_COUNT_ADDR);
  assign hitAny     = hitCtrl || hitStatus || hitCount;

  // Control writes are refused outside RUN so held settings stay as entered.
  assign ctrlWriteRefused = pwrite && hitCtrl && (state != hsc_pkg::ST_RUN);            // [R3]
  assign ctrlWrite        = accessDone && pwrite && hitCtrl && (state == hsc_pkg::ST_RUN);
  assign next_ctrl        = ctrlWrite ? hsc_pkg::hsc_ctrl_type'(pwdata[hsc_pkg::CTRL_WIDTH-1:0]) : ctrl;

  // Control register.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl <= hsc_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Status word shows the controller's own state.
  assign statusWord = '{lowOscStoppable: lowOscStoppable, haltFromSub: haltFromSub,
                        lastResume: lastResume, lastService: lastService, state: state};

  // Read data selection; unmapped addresses read zero.
  assign readWord = hitCtrl   ? {{(32-hsc_pkg::CTRL_WIDTH){1'b0}}, ctrl} :
                    hitStatus ? {{(32-hsc_pkg::STATUS_WIDTH){1'b0}}, statusWord} :
                    hitCount  ? {{(32-hsc_pkg::RELEASE_COUNT_WIDTH){1'b0}}, releaseCount} :
                    32'h0000_0000;

  // Answer is prepared in the setup cycle and held through the access cycle.
  assign next_prdata  = (setupPhase && !pwrite) ? readWord : (accessDone ? 32'h0000_0000 : prdata);
  assign next_pslverr = setupPhase ? (!hitAny || ctrlWriteRefused) : (accessDone ? 1'b0 : pslverr);

  // APB answer registers: one access cycle, never a wait.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= setupPhase;
      pslverr <= next_pslverr;
    end
  end

  // Wait states keep the hold active; the one-hot state is exported through status.
  // The external main clock input has no gate here: it follows the pin as applied.

endmodule : hsc_halt_control

// ### dv/hsc_halt_control_asserts.sv
// Concurrent checks on the ports of the HALT standby controller.
`timescale 1ns/1ps
module hsc_halt_control_asserts (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // CPU and interrupt controller
  input wire logic                 haltEntry,
  input wire logic                 cpuOnSubClock,
  input hsc_pkg::hsc_irq_flags_type irqFlags,
  input wire logic                 globalIrqEnable,
  input wire logic                 inServicePriorityFlag,
  // Controller outputs
  input wire logic                 cpuClockEnable,
  input wire logic                 executionHold,
  input wire logic                 subOscEnable,
  input wire logic                 fastOscEnable,
  input wire logic                 crystalOscEnable,
  input wire logic                 vectorStart,
  input wire logic                 resumeStart,
  input wire logic                 resetVectorStart
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Unmasked requests, and those among them that would be serviced.
  logic [7:0] pend;
  logic [7:0] svc;
  assign pend = irqFlags.request & ~irqFlags.mask;
  assign svc  = pend & (~irqFlags.lowPriority | {8{inServicePriorityFlag}});

  property p_halt_gate; haltEntry && !executionHold |=> !cpuClockEnable && executionHold; endproperty
  a_halt_gate: assert property (p_halt_gate) else $error("halt entry did not gate the cpu");
  property p_sub_osc; haltEntry && cpuOnSubClock && !executionHold |=> subOscEnable; endproperty
  a_sub_osc: assert property (p_sub_osc) else $error("sub oscillator off in halt");
  property p_osc_hold;
    !cpuClockEnable && !$past(cpuClockEnable) |-> $stable({subOscEnable, fastOscEnable, crystalOscEnable});
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator changed in halt");
  property p_masked; !cpuClockEnable && pend == 8'h00 |=> !cpuClockEnable; endproperty
  a_masked: assert property (p_masked) else $error("left halt without unmasked request");
  property p_release; !cpuClockEnable && pend != 8'h00 |=> cpuClockEnable && executionHold; endproperty
  a_release: assert property (p_release) else $error("unmasked request did not end halt");
  property p_service; !cpuClockEnable && globalIrqEnable && svc != 8'h00 |-> ##[13:14] vectorStart; endproperty
  a_service: assert property (p_service) else $error("vectored start late or missing");
  property p_resume;
    !cpuClockEnable && pend != 8'h00 && !(globalIrqEnable && svc != 8'h00) |-> ##[6:7] resumeStart;
  endproperty
  a_resume: assert property (p_resume) else $error("resume start late or missing");
  property p_order; vectorStart || resumeStart |-> !executionHold && $past(executionHold); endproperty
  a_order: assert property (p_order) else $error("start pulse out of order");
  property p_reset_vec;
    $rose(reset_n) |-> cpuClockEnable && !executionHold ##1 resetVectorStart ##1 !resetVectorStart;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector start wrong");
endmodule : hsc_halt_control_asserts

bind hsc_halt_control hsc_halt_control_asserts chk (.sys_clk, .reset_n, .haltEntry, .cpuOnSubClock,
  .irqFlags, .globalIrqEnable, .inServicePriorityFlag, .cpuClockEnable, .executionHold, .subOscEnable,
  .fastOscEnable, .crystalOscEnable, .vectorStart, .resumeStart, .resetVectorStart);

// ### dv/hsc_cpu_model.sv
// Behavioural CPU core and interrupt controller facing the HALT controller.
`timescale 1ns/1ps
module hsc_cpu_model (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Restart pulses
  input  wire logic                  vectorStart,
  input  wire logic                  resumeStart,
  // Core and flag outputs
  output logic                       haltEntry,
  output logic                       cpuOnSubClock,
  output hsc_pkg::hsc_irq_flags_type irqFlags,
  output logic                       globalIrqEnable,
  output logic                       inServicePriorityFlag
);
  // Everything starts idle with no request pending.
  initial begin
    haltEntry = 1'b0;
    cpuOnSubClock = 1'b0;
    irqFlags = '0;
    globalIrqEnable = 1'b0;
    inServicePriorityFlag = 1'b0;
  end

  // One HALT pulse; the core never starts external-clock peripherals on the sub clock.
  task automatic halt(input logic sub);
    haltEntry <= 1'b1;
    cpuOnSubClock <= sub;
    @(posedge sys_clk);
    haltEntry <= 1'b0;
  endtask : halt

  // Presents a new set of interrupt controller flags.
  task automatic irq(input logic [7:0] rq, input logic [7:0] mk, input logic [7:0] lp,
                     input logic ie, input logic in_service_priority_flag);
    irqFlags <= '{request: rq, mask: mk, lowPriority: lp};
    globalIrqEnable <= ie;
    inServicePriorityFlag <= in_service_priority_flag;
  endtask : irq

  // A restart or a reset retires the pending requests, as the controller would.
  always @(posedge sys_clk) begin
    if (vectorStart || resumeStart || !reset_n) begin
      irqFlags.request <= 8'h00;
    end
  end
endmodule : hsc_cpu_model

// ### dv/halt_standby_control_test.sv
// Self-checking testbench of the HALT standby controller.
`timescale 1ns/1ps
module halt_standby_control_test;
  logic sys_clk = 1'b0;
  logic reset_n, strap, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, cpuClockEnable, executionHold, subOscEnable, fastOscEnable;
  logic crystalOscEnable, lowSpeedOscEnable, watchdogClockEnable, timer16Enable;
  logic vectorStart, resumeStart, resetVectorStart, haltEntry, cpuOnSub, ie, in_service_priority_flag;
  hsc_pkg::hsc_irq_flags_type irqFlags;
  int err_total = 0;
  int num_checks = 0;

  always #25 sys_clk = ~sys_clk;

  hsc_cpu_model cpu (.sys_clk(sys_clk), .reset_n(reset_n), .vectorStart(vectorStart),
    .resumeStart(resumeStart), .haltEntry(haltEntry), .cpuOnSubClock(cpuOnSub), .irqFlags(irqFlags),
    .globalIrqEnable(ie), .inServicePriorityFlag(in_service_priority_flag));
  hsc_halt_control uut (.sys_clk(sys_clk), .reset_n(reset_n), .haltEntry(haltEntry),
    .cpuOnSubClock(cpuOnSub), .optionLowOscStoppable(strap), .irqFlags(irqFlags), .globalIrqEnable(ie),
    .inServicePriorityFlag(in_service_priority_flag), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuClockEnable(cpuClockEnable),
    .executionHold(executionHold), .subOscEnable(subOscEnable), .fastOscEnable(fastOscEnable),
    .crystalOscEnable(crystalOscEnable), .lowSpeedOscEnable(lowSpeedOscEnable),
    .watchdogClockEnable(watchdogClockEnable), .timer16Enable(timer16Enable), .vectorStart(vectorStart),
    .resumeStart(resumeStart), .resetVectorStart(resetVectorStart));

  // Compares one result and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // One APB transfer, entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Reference outcome: 0 stays halted, 1 resumes, 2 services.
  function automatic int decide(input int rq, input int mk, input int lp, input int e, input int s);
    int k;
    decide = 0;
    for (k = 0; k < 8; k++) begin
      if (rq[k] && !mk[k]) begin
        if (decide == 0) decide = 1;
        if (e != 0 && (!lp[k] || s != 0)) decide = 2;
      end
    end
  endfunction : decide

  // One HALT entry and release with the chosen flags on a random source.
  task automatic trial(input int m, input int e, input int lp, input int s, input int sub);
    int src, n, kind;
    logic [7:0] rq, mk, lw;
    src = $urandom_range(7, 0);
    rq = 8'($urandom) | (8'h01 << src);
    mk = ~(8'h01 << src) | (m != 0 ? (8'h01 << src) : 8'h00);
    lw = 8'($urandom);
    lw[src] = lp[0];
    cpu.halt(sub[0]);
    @(posedge sys_clk);
    check({subOscEnable, crystalOscEnable, timer16Enable, watchdogClockEnable, cpuClockEnable, executionHold},
          {sub[0], 5'h1d});
    cpu.irq(rq, mk, lw, e[0], s[0]);
    kind = decide(rq, mk, lw, e, s);
    if (kind == 0) begin
      repeat (30) @(posedge sys_clk);
      check({cpuClockEnable, executionHold}, 2'b01);
      apb(1'b0, hsc_pkg::STATUS_ADDR, 32'h0);
      check({rd[6], rd[3:0]}, {sub[0], 4'h2});
      apb(1'b1, hsc_pkg::CTRL_ADDR, 32'h0);
      check(er, 1'b1);
      cpu.irq(rq, 8'h00, lw, 1'b0, s[0]);
      kind = 1;
    end
    n = 0;
    while (!(vectorStart || resumeStart) && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check({vectorStart, resumeStart}, kind == 2 ? 2'b10 : 2'b01);
    check((n - (kind == 2 ? 14 : 7)) inside {0, 1}, 1'b1);
    @(posedge sys_clk);
  endtask : trial

  // Main sequence.
  initial begin
    {reset_n, strap, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(48));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check({cpuClockEnable, executionHold, subOscEnable, fastOscEnable, crystalOscEnable, lowSpeedOscEnable,
           watchdogClockEnable, timer16Enable}, 8'hb6);
    @(posedge sys_clk);
    check(resetVectorStart, 1'b1);
    apb(1'b0, hsc_pkg::CTRL_ADDR, 32'h0);
    check(rd, 32'h21);
    apb(1'b0, 8'h0c, 32'h0);
    check(er, 1'b1);
    apb(1'b1, hsc_pkg::CTRL_ADDR, 32'h1d);
    repeat (2) @(posedge sys_clk);
    check({watchdogClockEnable, timer16Enable}, 2'b10);
    apb(1'b1, hsc_pkg::CTRL_ADDR, 32'h0b);
    for (int c = 0; c < 16; c++) begin
      trial(c / 8, (c / 4) % 2, (c / 2) % 2, c % 2, $urandom_range(1, 0));
    end
    apb(1'b0, hsc_pkg::RELEASE_COUNT_ADDR, 32'h0);
    check(rd, 32'd16);
    cpu.halt(1'b1);
    strap <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    check({cpuClockEnable, executionHold}, 2'b10);
    @(posedge sys_clk);
    check(resetVectorStart, 1'b1);
    apb(1'b1, hsc_pkg::CTRL_ADDR, 32'h25);
    repeat (2) @(posedge sys_clk);
    check({lowSpeedOscEnable, watchdogClockEnable}, 2'b00);
    results();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    results();
  end
endmodule : halt_standby_control_test
